//--- common/subskip_regs.svh
/*
  Register offsets, field positions, reset values and operation codes of
  the subtract, decrement-skip and set-memory execution block.
  Assumes byte addressing on a 32-bit APB bus, one register per word.
*/
`ifndef SUBSKIP_REGS_SVH
`define SUBSKIP_REGS_SVH

// Register byte offsets
`define OFS_CMD 8'h00
`define OFS_WORK 8'h04
`define OFS_FLAGS 8'h08
`define OFS_STATUS 8'h0C
`define OFS_MEM_ADDR 8'h10
`define OFS_MEM_DATA 8'h14

// Command register fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_ARG_LSB 8
`define CMD_ARG_MSB 15

// Status register fields
`define STATUS_BUSY_BIT 0
`define STATUS_SKIP_BIT 1

// Operation codes
`define OP_SBC_IMM 3'h1
`define OP_SBC_MEM 3'h2
`define OP_SBC_TO_MEM 3'h3
`define OP_DEC_SKIP 3'h4
`define OP_DEC_SKIP_WORK 3'h5
`define OP_SET_MEM 3'h6

// Reset values and constants
`define WORK_RESET 8'h00
`define FLAGS_RESET 6'h00
`define BYTE_ALL_ONES 8'hFF
`define BYTE_ONE 8'h01

`endif

//--- common/subskip_pkg.sv
/*
  Types of the subtract, decrement-skip and set-memory execution block.
  Assumes subskip_regs.svh is on the include path.
*/
`include "subskip_regs.svh"

package subskip_pkg;

  // Execution sequence
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_EXEC,
    ST_DUMMY
  } exec_state_t;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic compare_zero_flag;
    logic signed_compare_flag;
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } flags_t;

  // Result of one subtract with borrow
  typedef struct packed {
    logic [7:0] diff;
    flags_t flags;
  } sub_result_t;

  // Whole state of the execution block
  typedef struct packed {
    exec_state_t state;
    logic [2:0] op;
    logic [7:0] operand;
    logic [7:0] work_register;
    flags_t flags;
    logic [7:0] mem_addr;
    logic last_skip;
    logic skip_next;
    logic dummy_cycle;
    logic busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } exec_regs_t;

endpackage : subskip_pkg

//--- rtl/subskip_mem.sv
/*
  Small single-port-write, registered-read data memory.
  Assumes one clock; read data reflect the address one edge earlier.
*/
`timescale 1ns/1ps

module subskip_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule : subskip_mem

//--- rtl/subskip_exec.sv
/*
  APB-controlled execution unit for subtract with borrow, decrement and
  skip if zero, and set data memory byte, with its own data memory.
  Assumes a 125 MHz pclk, inputs synchronous to pclk, and an APB master.
*/
// Decided for this implementation: the APB register port and the address map.
//
// Behaviour
// - Immediate subtract: work minus immediate minus inverted carry into work
// - After subtract, carry cleared if difference negative, else set
// - Subtracts update overflow, zero, half carry, carry, compare flags
// - Memory-destination subtract stores work minus memory minus borrow to memory
// - Decrement-skip writes memory minus one back; skip next if zero
// - A skip inserts one dummy cycle, three busy cycles in total
// - Decrement-skip to work loads memory minus one; memory unchanged
// - Set-memory writes all ones into the addressed byte
`timescale 1ns/1ps
`include "subskip_regs.svh"

module subskip_exec
  import subskip_pkg::*;
#(
  parameter int MEM_DEPTH = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic skip_next,
  output logic dummy_cycle,
  output logic busy
);

  exec_regs_t r_reg;
  exec_regs_t r_next;
  logic mem_we;
  logic [7:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_raddr;
  logic [7:0] mem_rdata;
  sub_result_t sub;
  logic [7:0] sub_rhs;
  logic [7:0] dec;
  logic do_skip;

  // Address decode shared by read and write paths
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  function automatic logic mapped(input logic [7:0] a);
    mapped = is_reg(a, `OFS_CMD) || is_reg(a, `OFS_WORK) ||
             is_reg(a, `OFS_FLAGS) || is_reg(a, `OFS_STATUS) ||
             is_reg(a, `OFS_MEM_ADDR) || is_reg(a, `OFS_MEM_DATA);
  endfunction : mapped

  // Subtract with borrow: a - b - not carry, with all six flags
  function automatic sub_result_t sub_borrow(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic c);
    sub_result_t s;
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
    s.diff = full[7:0];
    s.flags.carry_flag = ~full[8];
    s.flags.half_carry_flag = ~low[4];
    s.flags.zero_flag = (full[7:0] == 8'h00);
    s.flags.overflow_flag = (a[7] != b[7]) && (full[7] != a[7]);
    s.flags.signed_compare_flag = s.flags.overflow_flag ^ full[7];
    s.flags.compare_zero_flag = s.flags.zero_flag;
    sub_borrow = s;
  endfunction : sub_borrow

  // Memory read follows the operand while busy, else the window address
  assign mem_raddr = (r_reg.state == ST_IDLE) ? r_reg.mem_addr
                                              : r_reg.operand;

  // Operation datapath
  always_comb begin
    sub_rhs = (r_reg.op == `OP_SBC_IMM) ? r_reg.operand : mem_rdata;
    sub = sub_borrow(r_reg.work_register, sub_rhs,
                     r_reg.flags.carry_flag);
    dec = mem_rdata - `BYTE_ONE;
    do_skip = (dec == 8'h00) && ((r_reg.op == `OP_DEC_SKIP) ||
                                 (r_reg.op == `OP_DEC_SKIP_WORK));
  end

  // Next state: APB slave, then execution sequence
  always_comb begin
    r_next = r_reg;
    r_next.skip_next = 1'b0;
    mem_we = 1'b0;
    mem_waddr = r_reg.operand;
    mem_wdata = 8'h00;
    if (psel && penable && !r_reg.pready) begin
      // First access cycle: prepare answer, complete next edge
      r_next.pready = 1'b1;
      r_next.pslverr = ~mapped(paddr);
      r_next.prdata = 32'h0000_0000;
      if (is_reg(paddr, `OFS_CMD)) begin
        r_next.prdata[`CMD_OP_MSB:`CMD_OP_LSB] = r_reg.op;
        r_next.prdata[`CMD_ARG_MSB:`CMD_ARG_LSB] = r_reg.operand;
      end else if (is_reg(paddr, `OFS_WORK)) begin
        r_next.prdata[7:0] = r_reg.work_register;
      end else if (is_reg(paddr, `OFS_FLAGS)) begin
        r_next.prdata[5:0] = r_reg.flags;
      end else if (is_reg(paddr, `OFS_STATUS)) begin
        r_next.prdata[`STATUS_BUSY_BIT] = r_reg.busy;
        r_next.prdata[`STATUS_SKIP_BIT] = r_reg.last_skip;
      end else if (is_reg(paddr, `OFS_MEM_ADDR)) begin
        r_next.prdata[7:0] = r_reg.mem_addr;
      end else if (is_reg(paddr, `OFS_MEM_DATA)) begin
        r_next.prdata[7:0] = mem_rdata;
      end
    end else if (r_reg.pready) begin
      // Completing edge: writes take effect here
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
      if (psel && penable && pwrite) begin
        if (is_reg(paddr, `OFS_CMD) && r_reg.state == ST_IDLE) begin
          r_next.op = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
          r_next.operand = pwdata[`CMD_ARG_MSB:`CMD_ARG_LSB];
          r_next.state = ST_LOAD;
          r_next.busy = 1'b1;
          r_next.last_skip = 1'b0;
        end else if (is_reg(paddr, `OFS_WORK)) begin
          r_next.work_register = pwdata[7:0];
        end else if (is_reg(paddr, `OFS_FLAGS)) begin
          r_next.flags = pwdata[5:0];
        end else if (is_reg(paddr, `OFS_MEM_ADDR)) begin
          r_next.mem_addr = pwdata[7:0];
        end else if (is_reg(paddr, `OFS_MEM_DATA) &&
                     r_reg.state == ST_IDLE) begin
          mem_we = 1'b1;
          mem_waddr = r_reg.mem_addr;
          mem_wdata = pwdata[7:0];
        end
      end
    end
    // Execution sequence; its updates override same-cycle bus writes
    unique case (r_reg.state)
      ST_IDLE: begin
      end
      ST_LOAD: begin
        r_next.state = ST_EXEC;
      end
      ST_EXEC: begin
        case (r_reg.op)
          `OP_SBC_IMM, `OP_SBC_MEM: begin
            r_next.work_register = sub.diff;
            r_next.flags = sub.flags;
          end
          `OP_SBC_TO_MEM: begin
            mem_we = 1'b1;
            mem_wdata = sub.diff;
            r_next.flags = sub.flags;
          end
          `OP_DEC_SKIP: begin
            mem_we = 1'b1;
            mem_wdata = dec;
          end
          `OP_DEC_SKIP_WORK: begin
            r_next.work_register = dec;
          end
          `OP_SET_MEM: begin
            mem_we = 1'b1;
            mem_wdata = `BYTE_ALL_ONES;
          end
          default: begin
          end
        endcase
        r_next.skip_next = do_skip;
        r_next.last_skip = do_skip;
        r_next.dummy_cycle = do_skip;
        r_next.state = do_skip ? ST_DUMMY : ST_IDLE;
        r_next.busy = do_skip;
      end
      ST_DUMMY: begin
        r_next.dummy_cycle = 1'b0;
        r_next.busy = 1'b0;
        r_next.state = ST_IDLE;
      end
    endcase
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{state: ST_IDLE, op: 3'h0, operand: 8'h00,
                 work_register: `WORK_RESET, flags: `FLAGS_RESET,
                 mem_addr: 8'h00, last_skip: 1'b0, skip_next: 1'b0,
                 dummy_cycle: 1'b0, busy: 1'b0, pready: 1'b0,
                 pslverr: 1'b0, prdata: 32'h0000_0000};
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Data memory
  subskip_mem #(
    .WIDTH(8),
    .DEPTH(MEM_DEPTH),
    .AW(8)
  ) u_mem (
    .clk(pclk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Outputs straight from flops
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign skip_next = r_reg.skip_next;
  assign dummy_cycle = r_reg.dummy_cycle;
  assign busy = r_reg.busy;

endmodule : subskip_exec

//--- verification/subskip_exec_properties.sv
/*
  Port checker of the subtract, decrement-skip and set-memory unit.
  Assumes binding to subskip_exec with ce held high by the bench.
*/
`timescale 1ns/1ps
`include "subskip_regs.svh"

module subskip_exec_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic skip_next,
  input wire logic dummy_cycle,
  input wire logic busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Steps of one instruction
  sequence s_cmd;
    psel && penable && pwrite && pready && paddr == `OFS_CMD && !busy;
  endsequence
  sequence s_run;
    busy [*2] ##[1:2] !busy;
  endsequence

  // Instruction timing
  property p_start; s_cmd |=> busy; endproperty
  property p_len; $rose(busy) |-> s_run; endproperty
  property p_skip; skip_next |-> dummy_cycle && busy; endproperty
  property p_pulse; skip_next |=> !skip_next && !dummy_cycle; endproperty
  property p_end; dummy_cycle |=> !busy; endproperty
  // Bus answer timing
  property p_wait; $rose(penable) && psel |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty

  a_start: assert property (p_start) else $error("busy missing");
  a_len: assert property (p_len) else $error("bad length");
  a_skip: assert property (p_skip) else $error("no dummy");
  a_pulse: assert property (p_pulse) else $error("long skip");
  a_end: assert property (p_end) else $error("busy late");
  a_wait: assert property (p_wait) else $error("no ready");
  a_one: assert property (p_one) else $error("long ready");
  a_err: assert property (p_err) else $error("error data");
endmodule : subskip_exec_properties

bind subskip_exec subskip_exec_properties chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .skip_next,
  .dummy_cycle, .busy);

//--- verification/subskip_exec_bench.sv
/*
  Self-checking bench of the subtract, decrement-skip and set-memory unit.
  Assumes the package and subskip_regs.svh are compiled first.
*/
`timescale 1ns/1ps
`include "subskip_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module subskip_exec_bench;
  import subskip_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, w, a, m;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [5:0] f;
  logic pready, pslverr, skip_next, dummy_cycle, busy, er, sk, dm;
  logic [15:0] rnd = 16'h000E;
  int fails = 0, n_tests = 0, cyc = 0;

  subskip_exec uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .skip_next,
    .dummy_cycle, .busy);

  // Clock
  initial forever #4 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      final_report;
    end
  end

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Reference subtract with borrow
  // Carry, half carry, overflow and signed compare from whole-integer arithmetic; zero flags from result bits
  function sub_result_t subtract_with_borrow_op(input logic [7:0] x, y, input logic c);
    int sd;
    sub_result_t r;
    sd = int'($signed(x)) - int'($signed(y)) - int'(!c);
    r.diff = x - y - {7'h00, !c};
    r.flags.carry_flag = int'(x) >= int'(y) + int'(!c);
    r.flags.half_carry_flag = int'(x[3:0]) >= int'(y[3:0]) + int'(!c);
    r.flags.zero_flag = r.diff == 8'h00;
    r.flags.overflow_flag = sd < -128 || sd > 127;
    r.flags.signed_compare_flag = sd < 0;
    r.flags.compare_zero_flag = r.flags.zero_flag;
    return r;
  endfunction : subtract_with_borrow_op

  // One APB transfer, released after the ready edge
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Ready sampled at the rising edge; hang guard ends a stuck wait
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Load operands, run one op, check all results
  task run(input logic [2:0] op);
    sub_result_t r;
    logic [7:0] ew, em;
    logic [5:0] ef;
    logic es;
    int n;
    apb(1, `OFS_WORK, {24'h0, w});
    apb(1, `OFS_FLAGS, {26'h0, f});
    apb(1, `OFS_MEM_ADDR, {24'h0, a});
    apb(1, `OFS_MEM_DATA, {24'h0, m});
    r = subtract_with_borrow_op(w, (op == `OP_SBC_IMM) ? a : m, f[0]);
    ew = w;
    ef = f;
    em = m;
    es = m == 8'h01;
    case (op)
      `OP_SBC_IMM, `OP_SBC_MEM: begin ew = r.diff; ef = r.flags; es = 0; end
      `OP_SBC_TO_MEM: begin em = r.diff; ef = r.flags; es = 0; end
      `OP_DEC_SKIP: em = m - 8'h01;
      `OP_DEC_SKIP_WORK: ew = m - 8'h01;
      `OP_SET_MEM: begin em = 8'hFF; es = 0; end
      default: es = 0;
    endcase
    apb(1, `OFS_CMD, {16'h0, a, 5'h0, op});
    sk = 0;
    dm = 0;
    n = 0;
    // Count edges with busy high, catch one-cycle pulses
    @(posedge pclk);
    while (busy !== 1'b0) begin
      sk |= skip_next;
      dm |= dummy_cycle;
      n++;
      @(posedge pclk);
    end
    apb(0, `OFS_WORK, 0);
    `CHK("work", ew, rd[7:0])
    apb(0, `OFS_FLAGS, 0);
    `CHK("flags", ef, rd[5:0])
    apb(0, `OFS_MEM_DATA, 0);
    `CHK("mem", em, rd[7:0])
    apb(0, `OFS_STATUS, 0);
    `CHK("status skip", es, rd[1])
    `CHK("status busy", 1'b0, rd[0])
    `CHK("skip pulse", es, sk)
    `CHK("dummy cycle", es, dm)
    `CHK("busy cycles", es ? 3 : 2, n)
    $display("op %0d done", op);
  endtask : run

  task final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  // Reset, register defaults, bad address, then op sweep
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, `OFS_WORK, 0);
    `CHK("work reset", 32'h0, rd)
    apb(0, `OFS_FLAGS, 0);
    `CHK("flags reset", 32'h0, rd)
    `CHK("good addr err", 1'b0, er)
    apb(0, 8'h40, 0);
    `CHK("bad addr err", 1'b1, er)
    `CHK("bad addr data", 32'h0, rd)
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      w = rnd[7:0];
      f = rnd[13:8];
      rnd = lfsr(rnd);
      a = rnd[7:0];
      m = (i % 5 == 0) ? 8'h01 : (i % 5 == 1) ? 8'h00 : rnd[15:8];
      run(3'(i % 8));
    end
    // Second reset after the op sweep, registers back to defaults
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, `OFS_WORK, 0);
    `CHK("work rearm", 32'h0, rd)
    apb(0, `OFS_STATUS, 0);
    `CHK("status rearm", 32'h0, rd)
    final_report;
  end
endmodule : subskip_exec_bench
